// file: rtl/capture_unit.sv
// Edge capture sequencer for pulse width and period measurement
`timescale 1ns/100ps
`default_nettype none
module capture_unit (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic active_in,
    input wire logic period_mode_in,
    input wire logic polarity_in,
    input wire logic pin_in,
    input wire logic [timer_channel_pkg::CW-1:0] time_in,
    output logic lead_we_out,
    output logic trail_we_out,
    output logic done_out
);
    typedef enum logic [1:0] {CAP_IDLE, CAP_WAIT_LEAD, CAP_WAIT_TRAIL} cap_state_e;
    cap_state_e state_q, state_d;
    logic pin_q, pin_d;
    logic rise, fall, lead, trail;

    // ---------------------------------------------------------------
    // Edge detection
    // ---------------------------------------------------------------
    always_comb begin
        pin_d = pin_in;
        rise = pin_in && !pin_q;
        fall = !pin_in && pin_q;
        lead = polarity_in ? rise : fall;
        trail = period_mode_in ? lead : (polarity_in ? fall : rise);
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        lead_we_out = 1'b0;
        trail_we_out = 1'b0;
        done_out = 1'b0;
        case (state_q)
            CAP_IDLE: begin
                if (active_in) begin
                    state_d = CAP_WAIT_LEAD;
                end
            end
            CAP_WAIT_LEAD: begin
                if (lead) begin
                    lead_we_out = 1'b1;
                    state_d = CAP_WAIT_TRAIL;
                end
            end
            CAP_WAIT_TRAIL: begin
                if (trail) begin
                    trail_we_out = 1'b1;
                    done_out = 1'b1;
                    state_d = CAP_WAIT_LEAD;
                end
            end
            default: state_d = CAP_IDLE;
        endcase
        if (!active_in) begin
            state_d = CAP_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= CAP_IDLE;
            pin_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pin_q <= pin_d;
        end
    end
endmodule : capture_unit
`default_nettype wire

// file: rtl/timer_channel_pkg.sv
// Constants shared by the timer channel block
package timer_channel_pkg;
    localparam int NUM_CH = 4;
    localparam int CW = 16;
    localparam int CH_W = 2;
    localparam int ADDR_W = 8;
    // Register index layout: address = {channel, register}
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_MATCH_A = 3'h1;
    localparam logic [2:0] REG_MATCH_B = 3'h2;
    localparam logic [2:0] REG_COUNT = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_DISABLE = 8'hF0;
    localparam int REG_SEL_W = 3;
    localparam int CH_SHIFT = 3;
    // Control register fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 5;
    localparam int POL_BIT = 7;
    localparam int BSL_LSB = 8;
    localparam int BSL_W = 2;
    localparam int PRE_LSB = 10;
    localparam int PRE_W = 2;
    localparam int PREN_BIT = 12;
    localparam int UPD_BIT = 13;
    localparam int FLAG_BIT = 0;
    // Mode codes
    localparam logic [MODE_W-1:0] MODE_GPIN = 5'h00;
    localparam logic [MODE_W-1:0] MODE_GPOUT = 5'h01;
    localparam logic [MODE_W-1:0] MODE_PWIDTH = 5'h04;
    localparam logic [MODE_W-1:0] MODE_PERIOD = 5'h05;
    localparam logic [MODE_W-1:0] MODE_PWM = 5'h08;
    localparam logic [MODE_W-1:0] MODE_MODCNT = 5'h10;
    // Time base select codes
    localparam logic [BSL_W-1:0] BSL_BUS_A = 2'h0;
    localparam logic [BSL_W-1:0] BSL_BUS_B = 2'h1;
    localparam logic [BSL_W-1:0] BSL_INTERNAL = 2'h3;
    // Channels that drive the counter buses
    localparam int BUS_A_CH = NUM_CH - 1;
    localparam int BUS_B_CH = 0;
    localparam logic [NUM_CH-1:0] DISABLE_RST = 4'hF;
    localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CW-1:0] CNT_ONE = 16'h0001;
    localparam logic [PRE_W-1:0] PRE_ZERO = 2'h0;
    localparam logic [PRE_W-1:0] PRE_ONE = 2'h1;
endpackage : timer_channel_pkg

// file: rtl/timer_channels.sv
// Unified timer channels: modulus counter, PWM and capture
`timescale 1ns/100ps
`default_nettype none
module timer_channels (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [timer_channel_pkg::ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [timer_channel_pkg::NUM_CH-1:0] pin_in,
    output logic [31:0] rdata_out,
    output logic [timer_channel_pkg::NUM_CH-1:0] pin_out,
    output logic [timer_channel_pkg::NUM_CH-1:0] flag_out
);
    localparam int N = timer_channel_pkg::NUM_CH;
    localparam int CW = timer_channel_pkg::CW;

    logic [N-1:0] dis_q, dis_d;
    logic [15:0] ctrl_q [N], ctrl_d [N];
    logic [CW-1:0] a_q [N], a_d [N], b_q [N], b_d [N];
    logic [CW-1:0] a_act_q [N], a_act_d [N], b_act_q [N], b_act_d [N];
    logic [CW-1:0] cnt_q [N], cnt_d [N];
    logic [1:0] pre_q [N], pre_d [N];
    logic [N-1:0] out_q, out_d, flag_q, flag_d;
    logic [31:0] rdata_d;
    logic [CW-1:0] bus_a_q, bus_a_d, bus_b_q, bus_b_d;
    logic [CW-1:0] tb [N];
    logic [N-1:0] tb_restart, lead_we, trail_we, cap_done, cap_active, period_sel;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [4:0] mode_of(input logic [15:0] c);
        mode_of = c[timer_channel_pkg::MODE_LSB +: timer_channel_pkg::MODE_W];
    endfunction : mode_of

    function automatic logic hit(input logic [CW-1:0] addr_ch, input int ch,
                                 input logic [2:0] reg_sel,
                                 input logic [2:0] want);
        hit = (addr_ch == CW'(ch)) && (reg_sel == want);
    endfunction : hit

    // ---------------------------------------------------------------
    // Capture sequencers
    // ---------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_cap
        assign cap_active[i] = !dis_q[i] &&
            (mode_of(ctrl_q[i]) == timer_channel_pkg::MODE_PWIDTH ||
             mode_of(ctrl_q[i]) == timer_channel_pkg::MODE_PERIOD);
        assign period_sel[i] = mode_of(ctrl_q[i]) == timer_channel_pkg::MODE_PERIOD;
        capture_unit u_cap (
            .clk_sys_in(clk_sys_in),
            .arst_n_in(arst_n_in),
            .active_in(cap_active[i]),
            .period_mode_in(period_sel[i]),
            .polarity_in(ctrl_q[i][timer_channel_pkg::POL_BIT]),
            .pin_in(pin_in[i]),
            .time_in(tb[i]),
            .lead_we_out(lead_we[i]),
            .trail_we_out(trail_we[i]),
            .done_out(cap_done[i])
        );
    end

    // ---------------------------------------------------------------
    // Time base selection
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N; i++) begin
            case (ctrl_q[i][timer_channel_pkg::BSL_LSB +: timer_channel_pkg::BSL_W])
                timer_channel_pkg::BSL_BUS_A: tb[i] = bus_a_q;
                timer_channel_pkg::BSL_BUS_B: tb[i] = bus_b_q;
                default: tb[i] = cnt_q[i];
            endcase
            // PWM frequency mode style: internal counter not used for bus modes
            tb_restart[i] = (tb[i] == timer_channel_pkg::CNT_ZERO);
        end
    end

    // ---------------------------------------------------------------
    // Channel logic and register writes
    // ---------------------------------------------------------------
    always_comb begin
        logic [2:0] rsel;
        logic [CW-1:0] ach;
        logic tick;
        logic [4:0] md;
        logic set_ev;
        rsel = addr_in[timer_channel_pkg::REG_SEL_W-1:0];
        ach = CW'(addr_in[timer_channel_pkg::ADDR_W-1:timer_channel_pkg::CH_SHIFT]);
        tick = 1'b0;
        set_ev = 1'b0;
        md = timer_channel_pkg::MODE_GPIN;
        dis_d = dis_q;
        out_d = out_q;
        flag_d = flag_q;
        // Buses move only while their driver counts modulus
        // Bus copies lag the driving counter by one clock
        bus_a_d = bus_a_q;
        bus_b_d = bus_b_q;
        if (mode_of(ctrl_q[timer_channel_pkg::BUS_A_CH]) == timer_channel_pkg::MODE_MODCNT) begin
            bus_a_d = cnt_q[timer_channel_pkg::BUS_A_CH];
        end
        if (mode_of(ctrl_q[timer_channel_pkg::BUS_B_CH]) == timer_channel_pkg::MODE_MODCNT) begin
            bus_b_d = cnt_q[timer_channel_pkg::BUS_B_CH];
        end
        if (wr_in && addr_in == timer_channel_pkg::ADDR_DISABLE) begin
            dis_d = wdata_in[N-1:0];
        end
        for (int i = 0; i < N; i++) begin
            ctrl_d[i] = ctrl_q[i];
            a_d[i] = a_q[i];
            b_d[i] = b_q[i];
            a_act_d[i] = a_act_q[i];
            b_act_d[i] = b_act_q[i];
            cnt_d[i] = cnt_q[i];
            pre_d[i] = pre_q[i];
            md = mode_of(ctrl_q[i]);
            // Events this cycle beat a same-cycle flag clear
            set_ev = 1'b0;
            // Prescaler: field value p divides by p+1, zero passes every clock
            tick = !ctrl_q[i][timer_channel_pkg::PREN_BIT] || (pre_q[i] ==
                   ctrl_q[i][timer_channel_pkg::PRE_LSB +: timer_channel_pkg::PRE_W]);
            if (tick) begin
                pre_d[i] = timer_channel_pkg::PRE_ZERO;
            end else begin
                pre_d[i] = pre_q[i] + timer_channel_pkg::PRE_ONE;
            end
            if (!dis_q[i]) begin
                if (md == timer_channel_pkg::MODE_MODCNT && tick) begin
                    if (cnt_q[i] >= a_q[i]) begin
                        cnt_d[i] = timer_channel_pkg::CNT_ZERO;
                        flag_d[i] = 1'b1;
                        set_ev = 1'b1;
                    end else begin
                        cnt_d[i] = cnt_q[i] + timer_channel_pkg::CNT_ONE;
                    end
                end else if (md != timer_channel_pkg::MODE_MODCNT && tick) begin
                    cnt_d[i] = cnt_q[i] + timer_channel_pkg::CNT_ONE;
                end
                if (md == timer_channel_pkg::MODE_GPOUT) begin
                    out_d[i] = ctrl_q[i][timer_channel_pkg::POL_BIT];
                end
                if (md == timer_channel_pkg::MODE_PWM) begin
                    // Matches use the active copies so a write never glitches mid-cycle while UPD_BIT is clear
                    if (tb[i] == a_act_q[i]) begin
                        out_d[i] = ctrl_q[i][timer_channel_pkg::POL_BIT];
                    end
                    if (tb[i] == b_act_q[i]) begin
                        out_d[i] = !ctrl_q[i][timer_channel_pkg::POL_BIT];
                        flag_d[i] = 1'b1;
                        set_ev = 1'b1;
                    end
                end
                // Flag waits for the trailing capture so A and B are both valid
                if (cap_done[i]) begin
                    flag_d[i] = 1'b1;
                    set_ev = 1'b1;
                end
                if (lead_we[i]) begin
                    b_d[i] = tb[i];
                end
                if (trail_we[i]) begin
                    a_d[i] = tb[i];
                end
            end
            // Immediate update copies at once; next-period waits for base restart
            if (ctrl_q[i][timer_channel_pkg::UPD_BIT] || tb_restart[i]) begin
                a_act_d[i] = a_q[i];
                b_act_d[i] = b_q[i];
            end
            if (wr_in && ach == CW'(i) && addr_in != timer_channel_pkg::ADDR_DISABLE) begin
                if (!dis_q[i]) begin
                    if (rsel == timer_channel_pkg::REG_CTRL) begin
                        ctrl_d[i] = wdata_in[15:0];
                        cnt_d[i] = timer_channel_pkg::CNT_ZERO;
                        a_act_d[i] = a_q[i];
                        b_act_d[i] = b_q[i];
                    end else if (rsel == timer_channel_pkg::REG_MATCH_A) begin
                        a_d[i] = wdata_in[CW-1:0];
                    end else if (rsel == timer_channel_pkg::REG_MATCH_B) begin
                        b_d[i] = wdata_in[CW-1:0];
                    end
                end
                // Set wins over clear: a same-cycle event keeps the flag
                if (rsel == timer_channel_pkg::REG_STATUS &&
                    wdata_in[timer_channel_pkg::FLAG_BIT] && !set_ev) begin
                    flag_d[i] = 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Read decode
    // ---------------------------------------------------------------
    always_comb begin
        logic [2:0] rsel;
        logic [CW-1:0] ach;
        rsel = addr_in[timer_channel_pkg::REG_SEL_W-1:0];
        ach = CW'(addr_in[timer_channel_pkg::ADDR_W-1:timer_channel_pkg::CH_SHIFT]);
        // Unmapped addresses read as zero
        rdata_d = 32'h0000_0000;
        if (rd_in) begin
            if (addr_in == timer_channel_pkg::ADDR_DISABLE) begin
                rdata_d = {{(32-N){1'b0}}, dis_q};
            end else begin
                for (int i = 0; i < N; i++) begin
                    if (hit(ach, i, rsel, timer_channel_pkg::REG_CTRL)) begin
                        rdata_d = {16'h0000, ctrl_q[i]};
                    end else if (hit(ach, i, rsel, timer_channel_pkg::REG_MATCH_A)) begin
                        rdata_d = {16'h0000, a_q[i]};
                    end else if (hit(ach, i, rsel, timer_channel_pkg::REG_MATCH_B)) begin
                        rdata_d = {16'h0000, b_q[i]};
                    end else if (hit(ach, i, rsel, timer_channel_pkg::REG_COUNT) &&
                                 i == timer_channel_pkg::BUS_B_CH &&
                                 mode_of(ctrl_q[i]) == timer_channel_pkg::MODE_MODCNT) begin
                        // Bus B driver shows the shared bus value, not its raw counter
                        rdata_d = {16'h0000, bus_b_q};
                    end else if (hit(ach, i, rsel, timer_channel_pkg::REG_COUNT)) begin
                        rdata_d = {16'h0000, cnt_q[i]};
                    end else if (hit(ach, i, rsel, timer_channel_pkg::REG_STATUS)) begin
                        rdata_d = {31'h0000_0000, flag_q[i]};
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dis_q <= timer_channel_pkg::DISABLE_RST;
            out_q <= '0;
            flag_q <= '0;
            rdata_out <= 32'h0000_0000;
            pin_out <= '0;
            flag_out <= '0;
            bus_a_q <= timer_channel_pkg::CNT_ZERO;
            bus_b_q <= timer_channel_pkg::CNT_ZERO;
            for (int i = 0; i < N; i++) begin
                ctrl_q[i] <= 16'h0000;
                a_q[i] <= timer_channel_pkg::CNT_ZERO;
                b_q[i] <= timer_channel_pkg::CNT_ZERO;
                a_act_q[i] <= timer_channel_pkg::CNT_ZERO;
                b_act_q[i] <= timer_channel_pkg::CNT_ZERO;
                cnt_q[i] <= timer_channel_pkg::CNT_ZERO;
                pre_q[i] <= timer_channel_pkg::PRE_ZERO;
            end
        end else begin
            dis_q <= dis_d;
            out_q <= out_d;
            flag_q <= flag_d;
            rdata_out <= rdata_d;
            pin_out <= out_d;
            flag_out <= flag_d;
            bus_a_q <= bus_a_d;
            bus_b_q <= bus_b_d;
            for (int i = 0; i < N; i++) begin
                ctrl_q[i] <= ctrl_d[i];
                a_q[i] <= a_d[i];
                b_q[i] <= b_d[i];
                a_act_q[i] <= a_act_d[i];
                b_act_q[i] <= b_act_d[i];
                cnt_q[i] <= cnt_d[i];
                pre_q[i] <= pre_d[i];
            end
        end
    end
endmodule : timer_channels
`default_nettype wire

// file: verif/pulse_source.sv
// External pulse source feeding a channel pin
`timescale 1ns/100ps
`default_nettype none
module pulse_source (
    input wire logic clk_sys_in,
    input wire logic en_in,
    input wire logic [7:0] high_in,
    input wire logic [7:0] low_in,
    output logic pin_out
);
    logic [7:0] cnt_q = 8'h01;
    // Pulses stay far below the 16-bit bus roll-over
    always @(posedge clk_sys_in) begin
        if (!en_in) begin
            pin_out <= 1'b0;
            cnt_q <= 8'h01;
        end else if (cnt_q >= (pin_out ? high_in : low_in)) begin
            pin_out <= !pin_out;
            cnt_q <= 8'h01;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : pulse_source
`default_nettype wire

// file: verif/timer_channels_chk.sv
// Port checker for the timer channel block
`timescale 1ns/100ps
`default_nettype none
module timer_channels_chk (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [3:0] pin_in,
    input wire logic [31:0] rdata_out,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] flag_out
);
    // ----------------------------------------
    // Shadow of disable mask and channel 2 setup
    // ----------------------------------------
    logic [3:0] dis_q;
    logic [4:0] mode_q;
    logic pol_q;
    logic prev_q;
    logic [2:0] age_q;
    wire cap_w = (mode_q == timer_channel_pkg::MODE_PWIDTH)
        || (mode_q == timer_channel_pkg::MODE_PERIOD);
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dis_q <= timer_channel_pkg::DISABLE_RST;
            mode_q <= timer_channel_pkg::MODE_GPIN;
            pol_q <= 1'b0;
            prev_q <= 1'b0;
            age_q <= 3'h7;
        end else begin
            if (wr_in && addr_in == 8'hF0) begin
                dis_q <= wdata_in[3:0];
            end
            // Ignored writes must not move the shadow either
            if (wr_in && addr_in == 8'h10 && !dis_q[2]) begin
                mode_q <= wdata_in[4:0];
                pol_q <= wdata_in[7];
            end
            prev_q <= pin_in[2];
            age_q <= (pin_in[2] != prev_q) ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    upper_zero_a: assert property (rd_in |=> rdata_out[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    idle_rdata_a: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
        else $error("read data outside read cycle");
    dis_read_a: assert property (rd_in && addr_in == 8'hF0 |=> rdata_out[3:0] == $past(dis_q))
        else $error("disable mask readback wrong");
    flag_hold_a: assert property (wr_in && addr_in == 8'h14 && !wdata_in[0] && flag_out[2]
        |=> flag_out[2])
        else $error("zero write cleared flag");
    flag_clear_a: assert property ($fell(flag_out[2]) |-> $past(wr_in)
        && $past(addr_in) == 8'h14 && $past(wdata_in[0]))
        else $error("flag fell without a write");
    cap_late_a: assert property ($rose(flag_out[2]) && cap_w |-> age_q <= 3'h4)
        else $error("capture flag not tied to an edge");
    width_edge_a: assert property ($rose(flag_out[2])
        && mode_q == timer_channel_pkg::MODE_PWIDTH |-> pin_in[2] == !pol_q)
        else $error("pulse width flag on wrong edge");
    period_edge_a: assert property ($rose(flag_out[2])
        && mode_q == timer_channel_pkg::MODE_PERIOD |-> pin_in[2] == pol_q)
        else $error("period flag on wrong edge");
endmodule : timer_channels_chk
bind timer_channels timer_channels_chk chk (.clk_sys_in, .arst_n_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .pin_in, .rdata_out, .pin_out, .flag_out);
`default_nettype wire

// file: verif/timer_channels_test.sv
// Self-checking testbench for the timer channel block
`timescale 1ns/100ps
`default_nettype none
module timer_channels_test;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic src_en = 1'b0;
    logic src_pin;
    logic [31:0] rdata_out;
    logic [3:0] pin_out;
    logic [3:0] flag_out;
    int n_fail = 0;
    int n_compared = 0;

    timer_channels DUT (.clk_sys_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .pin_in({pin_out[3], src_pin, pin_out[1:0]}), .rdata_out, .pin_out, .flag_out);
    pulse_source SRC (.clk_sys_in, .en_in(src_en), .high_in(8'h1E), .low_in(8'h32),
        .pin_out(src_pin));

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : bus_rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        bus_rd(a, v);
        check(v, exp, what);
    endtask : rd_chk
    task automatic sample_pin(output int hi, output int tg);
        logic p;
        hi = 0;
        tg = 0;
        @(posedge clk_sys_in);
        #1 p = pin_out[1];
        repeat (8) begin
            @(posedge clk_sys_in);
            #1;
            hi += (pin_out[1] === 1'b1);
            tg += (pin_out[1] !== p);
            p = pin_out[1];
        end
    endtask : sample_pin
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_enable();
        rd_chk(8'hF0, 32'h0000_000F, "disable after reset");
        bus_wr(8'h09, 32'h0000_1234);
        rd_chk(8'h09, 32'h0000_0000, "write while disabled");
        bus_wr(8'hF0, 32'h0000_0008);
        rd_chk(8'hF0, 32'h0000_0008, "disable readback");
        bus_wr(8'h09, 32'h0000_1234);
        rd_chk(8'h09, 32'h0000_1234, "write while enabled");
        bus_wr(8'h10, 32'h0000_0081);
        repeat (2) @(posedge clk_sys_in);
        #1;
        check(pin_out[2], 1'b1, "general output high");
        bus_wr(8'h10, 32'h0000_0001);
        repeat (2) @(posedge clk_sys_in);
        #1;
        check(pin_out[2], 1'b0, "general output low");
    endtask : t_enable
    task automatic t_modcnt();
        logic [31:0] v0, v1;
        bus_wr(8'h01, 32'h0000_0001);
        bus_wr(8'h00, 32'h0000_1310);
        bus_rd(8'h03, v0);
        @(posedge clk_sys_in);
        bus_rd(8'h03, v1);
        check(v0 ^ v1, 32'h0000_0001, "bus B step each clock");
        check(v0 | v1, 32'h0000_0001, "bus B wraps after 1");
        check(flag_out[0], 1'b1, "modulus flag");
    endtask : t_modcnt
    task automatic t_pwm();
        int hi, tg;
        bus_wr(8'h0A, 32'h0000_0000);
        bus_wr(8'h09, 32'h0000_0001);
        // Bus B selected, own prescaler left off
        bus_wr(8'h08, 32'h0000_0188);
        repeat (4) @(posedge clk_sys_in);
        sample_pin(hi, tg);
        check(hi, 4, "max rate duty");
        check(tg, 8, "max rate toggles");
        bus_wr(8'h01, 32'h0000_0003);
        repeat (8) @(posedge clk_sys_in);
        sample_pin(hi, tg);
        check(hi, 6, "high from A to B match");
        check(tg, 4, "period follows bus");
    endtask : t_pwm
    task automatic t_capture(input logic [31:0] ctrl, input logic [15:0] exp);
        logic [31:0] a, b;
        bus_wr(8'h10, 32'h0000_0000);
        bus_wr(8'h10, ctrl);
        bus_wr(8'h14, 32'h0000_0001);
        #1;
        for (int i = 0; i < 2000 && flag_out[2] !== 1'b1; i++) begin
            @(posedge clk_sys_in);
            #1;
        end
        check(flag_out[2], 1'b1, "capture flag");
        bus_rd(8'h11, a);
        bus_rd(8'h12, b);
        // Modulo subtraction also covers a bus wrap between edges
        check({16'h0000, a[15:0] - b[15:0]}, {16'h0000, exp}, "captured span");
    endtask : t_capture
    task automatic t_flag();
        src_en <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        bus_wr(8'h14, 32'h0000_0000);
        rd_chk(8'h14, 32'h0000_0001, "zero write keeps flag");
        bus_wr(8'h14, 32'h0000_0001);
        rd_chk(8'h14, 32'h0000_0000, "one write clears flag");
        check(flag_out[2], 1'b0, "flag pin cleared");
    endtask : t_flag
    // ----------------------------------------
    // Clock, sequence, watchdog, verdict
    // ----------------------------------------
    task automatic print_verdict();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (20) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        src_en <= 1'b1;
        t_enable();
        t_modcnt();
        t_pwm();
        bus_wr(8'h01, 32'h0000_FFFF);
        t_capture(32'h0000_0184, 16'h001E);
        t_capture(32'h0000_0104, 16'h0032);
        t_capture(32'h0000_0185, 16'h0050);
        t_capture(32'h0000_0105, 16'h0050);
        t_flag();
        print_verdict();
    end
    initial begin
        #200000;
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule : timer_channels_test
`default_nettype wire
